/* File: common/dsa_cfg.svh */
// address map, step sizes and reset values of the data space access unit
`ifndef DSA_CFG_SVH
`define DSA_CFG_SVH

`define DSA_EA_W 16
`define DSA_PAGE_W 8
`define DSA_EXT_W 24
`define DSA_NEAR_FIELD_W 13
`define DSA_SFR_FIRST 16'h0000
`define DSA_SFR_LAST 16'h0fff
`define DSA_NEAR_LAST 16'h1fff
`define DSA_RAM_FIRST 16'h1000
`define DSA_RAM_LAST 16'hcfff
`define DSA_XY_SPLIT 16'h8000
`define DSA_HOME_PAGE 8'h00
`define DSA_STEP_BYTE 16'h0001
`define DSA_STEP_WORD 16'h0002
`define DSA_WORD_ZERO 16'h0000
`define DSA_ADDR_ZERO 24'h000000
`define DSA_LANE_NONE 2'h0
`define DSA_LANE_LOW 2'h1
`define DSA_LANE_HIGH 2'h2
`define DSA_LANE_BOTH 2'h3

`endif

/* File: common/dsa_pkg.sv */
// types shared by the data space access unit and its helpers
package dsa_pkg;
	// kind of access presented by the execution pipeline
	typedef enum logic [1:0] {
		OP_READ,
		OP_WRITE,
		OP_MAC_READ,
		OP_IDLE
	} op_t;
	// effective address formation
	typedef enum logic [2:0] {
		AM_DIRECT13,
		AM_DIRECT16,
		AM_INDIRECT,
		AM_POST_INC,
		AM_POST_DEC,
		AM_MODULO,
		AM_BIT_REV
	} amode_t;
	// treatment of a byte loaded into a working register
	typedef enum logic [1:0] {
		EXT_NONE,
		EXT_SIGN,
		EXT_ZERO
	} ext_t;
	// decoded target of an effective address
	typedef enum logic [1:0] {
		REGION_SFR,
		REGION_RAM,
		REGION_NONE
	} region_t;
endpackage

/* File: common/agu_if.sv */
// request and result of one address generator
`timescale 1ns/1ps
`default_nettype none
interface agu_if;
	dsa_pkg::amode_t mode;
	logic byteOp;
	logic [15:0] direct;
	logic [15:0] pointer;
	logic [15:0] modStart;
	logic [15:0] modEnd;
	logic [15:0] revStep;
	logic [15:0] ea;
	logic [15:0] nextPointer;
	modport gen (input mode, byteOp, direct, pointer, modStart, modEnd, revStep,
		output ea, nextPointer);
	modport user (output mode, byteOp, direct, pointer, modStart, modEnd, revStep,
		input ea, nextPointer);
endinterface
`default_nettype wire

/* File: src/address_generator.sv */
// effective address and pointer post-modification
`timescale 1ns/1ps
`default_nettype none
`include "dsa_cfg.svh"
module address_generator #(
	parameter bit BIT_REV_OK = 1'b0
) (
	agu_if.gen agu
);
	import dsa_pkg::*;

	// reverse-carry add for bit-reversed buffers
	function automatic logic [15:0] revAdd(input logic [15:0] a, input logic [15:0] b);
		logic [15:0] ra;
		logic [15:0] rb;
		logic [15:0] s;
		ra = {<<{a}};
		rb = {<<{b}};
		s = ra + rb;
		return {<<{s}};
	endfunction

	logic [15:0] step;
	logic [15:0] incPtr;

	// byte ops step by one, word ops by two
	assign step = agu.byteOp ? `DSA_STEP_BYTE : `DSA_STEP_WORD;
	assign incPtr = agu.pointer + step;

	// address and next pointer per mode
	always_comb begin
		agu.ea = agu.pointer;
		agu.nextPointer = agu.pointer;
		unique case (agu.mode)
			AM_DIRECT13: agu.ea = {3'h0, agu.direct[`DSA_NEAR_FIELD_W-1:0]};
			AM_DIRECT16: agu.ea = agu.direct;
			AM_INDIRECT: agu.nextPointer = agu.pointer;
			AM_POST_INC: agu.nextPointer = incPtr;
			AM_POST_DEC: agu.nextPointer = agu.pointer - step;
			AM_MODULO: agu.nextPointer = (incPtr > agu.modEnd) ? agu.modStart : incPtr;
			AM_BIT_REV: agu.nextPointer = BIT_REV_OK ? revAdd(agu.pointer, agu.revStep) : incPtr;
			default: agu.nextPointer = agu.pointer;
		endcase
	end
endmodule // address_generator
`default_nettype wire

/* File: src/byte_lane_steer.sv */
// byte selection and working register merge for loads
`timescale 1ns/1ps
`default_nettype none
module byte_lane_steer (
	input wire logic [15:0] word,
	input wire logic oddByte,
	input wire logic byteOp,
	input wire dsa_pkg::ext_t ext,
	input wire logic [15:0] regOld,
	output logic [15:0] result
);
	import dsa_pkg::*;

	logic [7:0] lane;

	// odd address picks the high byte
	assign lane = oddByte ? word[15:8] : word[7:0];

	// place the byte in the low half of the register
	always_comb begin
		if (!byteOp) begin
			result = word;
		end else begin
			unique case (ext)
				EXT_SIGN: result = {{8{lane[7]}}, lane};
				EXT_ZERO: result = {8'h00, lane};
				default: result = {regOld[15:8], lane};
			endcase
		end
	end
endmodule // byte_lane_steer
`default_nettype wire

/* File: src/data_space_access_unit.sv */
// data space access unit: address decode, paging, lanes, alignment traps
// Notes on behaviour
// - effective addresses are 16 bits, each naming one byte of 64 KB
// - read page extends read addresses, write page write addresses, to 24 bits; only the home page is mapped
// - reads outside register area and RAM return zero
// - low byte sits at the even address, high byte at the odd
// - post-modify steps pointers by one for bytes, two for words
// - byte read fetches the word, bit 0 picks the byte, low lane
// - one word decode, separate byte write strobes per lane
// - word access at an odd address raises the address error trap
// - misaligned read completes, misaligned write is dropped, then trap
// - byte load fills the register low byte, high byte kept
// - sign extend and zero extend of a loaded byte
// - addresses 0x0000 to 0x0fff decode to control registers
// - unused control register addresses read as zero
// - direct instructions reach 0x0000 to 0x1fff with 13 bits
// - whole space reachable with 16-bit direct or pointer indirect
// - reads and writes use separate address generators
// - X space serves all modes, separate read and write buses
// - X read bus carries combined reads and the X operand of MAC
// - MAC class reads a Y word at the same time as X
// - modulo in X and Y, bit reversal only for X writes
// - writes see one combined space, fixed X/Y boundary
`timescale 1ns/1ps
`default_nettype none
`include "dsa_cfg.svh"
module data_space_access_unit #(
	parameter logic [15:0] RAM_LAST = `DSA_RAM_LAST,
	parameter logic [15:0] XY_SPLIT = `DSA_XY_SPLIT,
	parameter logic [7:0] HOME_PAGE = `DSA_HOME_PAGE
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic reqValid,
	input wire dsa_pkg::op_t reqOp,
	input wire logic reqByte,
	input wire dsa_pkg::amode_t reqMode,
	input wire logic [15:0] reqDirect,
	input wire logic [15:0] reqPointer,
	input wire logic [15:0] reqModStart,
	input wire logic [15:0] reqModEnd,
	input wire logic [15:0] reqRevStep,
	input wire dsa_pkg::ext_t reqExt,
	input wire logic [15:0] reqRegOld,
	input wire logic [15:0] reqWriteData,
	input wire dsa_pkg::amode_t macYMode,
	input wire logic [15:0] macYPointer,
	input wire logic [7:0] readPageSelect,
	input wire logic [7:0] writePageSelect,
	output logic [15:0] pointerNext,
	output logic [15:0] pointerNextY,
	output logic pointerValid,
	output logic rspValid,
	output logic [15:0] rspData,
	output logic macValid,
	output logic [15:0] macXData,
	output logic [15:0] macYData,
	output logic addrErrorTrap,
	output logic [15:0] trapAddr,
	output logic xRdEn,
	output logic [23:0] xRdAddr,
	output logic xRdSfr,
	input wire logic [15:0] xRdData,
	input wire logic xRdHit,
	output logic yRdEn,
	output logic [23:0] yRdAddr,
	input wire logic [15:0] yRdData,
	output logic [1:0] wrStrobe,
	output logic [23:0] wrAddr,
	output logic [15:0] wrData,
	output logic wrSfr
);
	import dsa_pkg::*;

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	// target of a base address within the home page
	function automatic region_t regionOf(input logic [15:0] ea, input logic [7:0] page);
		region_t r;
		r = REGION_NONE;
		if (page == HOME_PAGE) begin
			if (ea <= `DSA_SFR_LAST) begin
				r = REGION_SFR;
			end else if (ea >= `DSA_RAM_FIRST && ea <= RAM_LAST) begin
				r = REGION_RAM;
			end
		end
		return r;
	endfunction

	// page register in front of the byte address
	function automatic logic [23:0] extend(input logic [7:0] page, input logic [15:0] ea);
		return {page, ea};
	endfunction

	// word access must sit on an even address
	function automatic logic misaligned(input logic byteOp, input logic [15:0] ea);
		return !byteOp && ea[0];
	endfunction

	// ----------------------------------------
	// address generators
	// ----------------------------------------
	agu_if rdAgu ();
	agu_if wrAgu ();
	agu_if yAgu ();

	logic isRead;
	logic isWrite;
	logic isMac;

	assign isRead = reqValid && (reqOp == OP_READ || reqOp == OP_MAC_READ);
	assign isWrite = reqValid && reqOp == OP_WRITE;
	assign isMac = reqValid && reqOp == OP_MAC_READ;

	// the X read generator, also the MAC X prefetch path
	assign rdAgu.mode = reqMode;
	assign rdAgu.byteOp = reqByte && !isMac;
	assign rdAgu.direct = reqDirect;
	assign rdAgu.pointer = reqPointer;
	assign rdAgu.modStart = reqModStart;
	assign rdAgu.modEnd = reqModEnd;
	assign rdAgu.revStep = reqRevStep;

	// the write generator is a separate unit
	assign wrAgu.mode = reqMode;
	assign wrAgu.byteOp = reqByte;
	assign wrAgu.direct = reqDirect;
	assign wrAgu.pointer = reqPointer;
	assign wrAgu.modStart = reqModStart;
	assign wrAgu.modEnd = reqModEnd;
	assign wrAgu.revStep = reqRevStep;

	// the Y generator only sees MAC class word reads
	assign yAgu.mode = macYMode;
	assign yAgu.byteOp = 1'b0;
	assign yAgu.direct = `DSA_WORD_ZERO;
	assign yAgu.pointer = macYPointer;
	assign yAgu.modStart = reqModStart;
	assign yAgu.modEnd = reqModEnd;
	assign yAgu.revStep = reqRevStep;

	// reads never bit-reverse, X writes may
	address_generator #(.BIT_REV_OK(1'b0)) readGen (.agu(rdAgu));
	address_generator #(.BIT_REV_OK(1'b1)) writeGen (.agu(wrAgu));
	address_generator #(.BIT_REV_OK(1'b0)) yGen (.agu(yAgu));

	// ----------------------------------------
	// request decode
	// ----------------------------------------
	region_t rdRegion;
	region_t wrRegion;
	region_t yRegion;
	logic rdMisaligned;
	logic wrMisaligned;
	logic yMisaligned;
	logic wrAllowed;
	logic [15:0] wrLaneData;
	logic [1:0] wrLanes;

	assign rdRegion = regionOf(rdAgu.ea, readPageSelect);
	assign wrRegion = regionOf(wrAgu.ea, writePageSelect);
	assign rdMisaligned = misaligned(rdAgu.byteOp, rdAgu.ea);
	assign wrMisaligned = misaligned(wrAgu.byteOp, wrAgu.ea);
	assign yMisaligned = misaligned(1'b0, yAgu.ea);

	// the Y operand must lie in RAM above the fixed split
	assign yRegion = (yAgu.ea < XY_SPLIT) ? REGION_NONE : regionOf(yAgu.ea, readPageSelect);

	// drop misaligned and unmapped stores
	assign wrAllowed = isWrite && !wrMisaligned && wrRegion != REGION_NONE;

	// byte writes hit only the lane their address names
	always_comb begin
		if (!reqByte) begin
			wrLanes = `DSA_LANE_BOTH;
			wrLaneData = reqWriteData;
		end else begin
			wrLanes = wrAgu.ea[0] ? `DSA_LANE_HIGH : `DSA_LANE_LOW;
			wrLaneData = {reqWriteData[7:0], reqWriteData[7:0]};
		end
	end

	// ----------------------------------------
	// stage 1: memory addresses and pointer result
	// ----------------------------------------
	// X read bus address
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			xRdEn <= 1'b0;
			xRdAddr <= `DSA_ADDR_ZERO;
			xRdSfr <= 1'b0;
		end else begin
			xRdEn <= isRead && rdRegion != REGION_NONE;
			xRdAddr <= extend(readPageSelect, {rdAgu.ea[15:1], 1'b0});
			xRdSfr <= isRead && rdRegion == REGION_SFR;
		end
	end

	// Y read bus address, concurrent with X
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			yRdEn <= 1'b0;
			yRdAddr <= `DSA_ADDR_ZERO;
		end else begin
			yRdEn <= isMac && yRegion != REGION_NONE;
			yRdAddr <= extend(readPageSelect, yAgu.ea);
		end
	end

	// X write bus, with per-lane strobes
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wrStrobe <= `DSA_LANE_NONE;
			wrAddr <= `DSA_ADDR_ZERO;
			wrData <= `DSA_WORD_ZERO;
			wrSfr <= 1'b0;
		end else begin
			wrStrobe <= wrAllowed ? wrLanes : `DSA_LANE_NONE;
			wrAddr <= extend(writePageSelect, {wrAgu.ea[15:1], 1'b0});
			wrData <= wrLaneData;
			wrSfr <= wrAllowed && wrRegion == REGION_SFR;
		end
	end

	// updated pointers go back to the register file
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pointerValid <= 1'b0;
			pointerNext <= `DSA_WORD_ZERO;
			pointerNextY <= `DSA_WORD_ZERO;
		end else begin
			pointerValid <= isRead || isWrite;
			pointerNext <= isWrite ? wrAgu.nextPointer : rdAgu.nextPointer;
			pointerNextY <= yAgu.nextPointer;
		end
	end

	// address error trap one cycle after the access
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			addrErrorTrap <= 1'b0;
			trapAddr <= `DSA_WORD_ZERO;
		end else begin
			addrErrorTrap <= (isRead && rdMisaligned) || (isWrite && wrMisaligned)
				|| (isMac && yMisaligned);
			if (isWrite && wrMisaligned) begin
				trapAddr <= wrAgu.ea;
			end else if (isRead && rdMisaligned) begin
				trapAddr <= rdAgu.ea;
			end else if (isMac && yMisaligned) begin
				trapAddr <= yAgu.ea;
			end
		end
	end

	// ----------------------------------------
	// read bookkeeping across the memory latency
	// ----------------------------------------
	logic s1Valid_q;
	logic s1Mac_q;
	logic s1Byte_q;
	logic s1Odd_q;
	logic s1XLive_q;
	logic s1YLive_q;
	ext_t s1Ext_q;
	logic [15:0] s1RegOld_q;
	logic s2Valid_q;
	logic s2Mac_q;
	logic s2Byte_q;
	logic s2Odd_q;
	logic s2XLive_q;
	logic s2YLive_q;
	ext_t s2Ext_q;
	logic [15:0] s2RegOld_q;

	// stage 1 copy of the read request
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s1Valid_q <= 1'b0;
			s1Mac_q <= 1'b0;
			s1Byte_q <= 1'b0;
			s1Odd_q <= 1'b0;
			s1XLive_q <= 1'b0;
			s1YLive_q <= 1'b0;
			s1Ext_q <= EXT_NONE;
			s1RegOld_q <= `DSA_WORD_ZERO;
		end else begin
			s1Valid_q <= isRead;
			s1Mac_q <= isMac;
			s1Byte_q <= rdAgu.byteOp;
			s1Odd_q <= rdAgu.ea[0];
			s1XLive_q <= rdRegion != REGION_NONE;
			s1YLive_q <= yRegion != REGION_NONE;
			s1Ext_q <= reqExt;
			s1RegOld_q <= reqRegOld;
		end
	end

	// register area answers with its hit flag in the address cycle, one cycle before data returns
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s2Valid_q <= 1'b0;
			s2Mac_q <= 1'b0;
			s2Byte_q <= 1'b0;
			s2Odd_q <= 1'b0;
			s2XLive_q <= 1'b0;
			s2YLive_q <= 1'b0;
			s2Ext_q <= EXT_NONE;
			s2RegOld_q <= `DSA_WORD_ZERO;
		end else begin
			s2Valid_q <= s1Valid_q;
			s2Mac_q <= s1Mac_q;
			s2Byte_q <= s1Byte_q;
			s2Odd_q <= s1Odd_q;
			s2XLive_q <= s1XLive_q && (!xRdSfr || xRdHit);
			s2YLive_q <= s1YLive_q;
			s2Ext_q <= s1Ext_q;
			s2RegOld_q <= s1RegOld_q;
		end
	end

	// ----------------------------------------
	// stage 3: returned data
	// ----------------------------------------
	logic [15:0] xWord;
	logic [15:0] yWord;
	logic [15:0] loadValue;

	// unimplemented targets give a zero word
	assign xWord = s2XLive_q ? xRdData : `DSA_WORD_ZERO;
	assign yWord = s2YLive_q ? yRdData : `DSA_WORD_ZERO;

	byte_lane_steer laneSteer (
		.word(xWord),
		.oddByte(s2Odd_q),
		.byteOp(s2Byte_q),
		.ext(s2Ext_q),
		.regOld(s2RegOld_q),
		.result(loadValue)
	);

	// ordinary load result
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rspValid <= 1'b0;
			rspData <= `DSA_WORD_ZERO;
		end else begin
			rspValid <= s2Valid_q && !s2Mac_q;
			rspData <= loadValue;
		end
	end

	// both MAC operands arrive together
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			macValid <= 1'b0;
			macXData <= `DSA_WORD_ZERO;
			macYData <= `DSA_WORD_ZERO;
		end else begin
			macValid <= s2Valid_q && s2Mac_q;
			macXData <= xWord;
			macYData <= yWord;
		end
	end
endmodule // data_space_access_unit
`default_nettype wire

/* File: verification/data_space_access_unit_chk.sv */
// port assertions of the data space access unit
`timescale 1ns/1ps
`default_nettype none
module data_space_access_unit_chk #(
	parameter logic [15:0] RAM_LAST = 16'hcfff,
	parameter logic [15:0] XY_SPLIT = 16'h8000,
	parameter logic [7:0] HOME_PAGE = 8'h00
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic reqValid,
	input wire dsa_pkg::op_t reqOp,
	input wire logic reqByte,
	input wire dsa_pkg::amode_t reqMode,
	input wire logic [15:0] reqDirect,
	input wire logic [15:0] reqPointer,
	input wire logic [15:0] reqWriteData,
	input wire dsa_pkg::amode_t macYMode,
	input wire logic [15:0] macYPointer,
	input wire logic [7:0] readPageSelect,
	input wire logic [7:0] writePageSelect,
	input wire logic rspValid,
	input wire logic [15:0] rspData,
	input wire logic macValid,
	input wire logic addrErrorTrap,
	input wire logic [15:0] trapAddr,
	input wire logic xRdEn,
	input wire logic [23:0] xRdAddr,
	input wire logic xRdSfr,
	input wire logic yRdEn,
	input wire logic [1:0] wrStrobe,
	input wire logic [23:0] wrAddr,
	input wire logic [15:0] wrData
);
	import dsa_pkg::*;
	// ----------
	// checks
	// ----------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	wire logic rdReq = reqValid && reqOp == OP_READ && reqMode == AM_DIRECT16;
	wire logic wrReq = reqValid && reqOp == OP_WRITE && reqMode == AM_DIRECT16;
	wire logic rdMap = readPageSelect == HOME_PAGE && reqDirect <= RAM_LAST;
	wire logic wrMap = writePageSelect == HOME_PAGE && reqDirect <= RAM_LAST;
	logic [7:0] byteQ;
	logic oddQ;
	// byte and lane of the previous request
	always_ff @(posedge sys_clk) begin
		byteQ <= reqWriteData[7:0];
		oddQ <= reqDirect[0];
	end
	sequence zeroLoad;
		rspValid && rspData == 16'h0000;
	endsequence
	sequence bothRead;
		xRdEn && yRdEn;
	endsequence
	misalign_write_a: assert property (
		wrReq && !reqByte && reqDirect[0] && wrMap
		|=> addrErrorTrap && wrStrobe == 2'h0 && trapAddr == $past(reqDirect))
		else $error("odd word write kept");
	misalign_read_a: assert property (
		rdReq && !reqByte && reqDirect[0] && rdMap && reqDirect > 16'h0fff
		|=> (addrErrorTrap && xRdAddr[15:0] == ($past(reqDirect) & 16'hfffe)) ##2 rspValid)
		else $error("odd word read lost");
	byte_lane_a: assert property (
		wrReq && reqByte && wrMap
		|=> wrStrobe == (oddQ ? 2'h2 : 2'h1) && wrData == {byteQ, byteQ}
			&& wrAddr == {$past(writePageSelect), $past(reqDirect) & 16'hfffe})
		else $error("byte lanes wrong");
	read_page_a: assert property (
		rdReq && reqByte && rdMap
		|=> xRdEn && xRdAddr == {$past(readPageSelect), $past(reqDirect) & 16'hfffe})
		else $error("read not paged");
	unmapped_read_a: assert property (
		rdReq && !reqByte && !reqDirect[0] && !rdMap
		|=> !xRdEn ##2 zeroLoad)
		else $error("unmapped read not zero");
	unmapped_write_a: assert property (
		wrReq && reqByte && !wrMap
		|=> wrStrobe == 2'h0 && !addrErrorTrap)
		else $error("unmapped write kept");
	sfr_decode_a: assert property (
		rdReq && rdMap
		|=> xRdEn && xRdSfr == ($past(reqDirect) <= 16'h0fff))
		else $error("register area decode wrong");
	dual_fetch_a: assert property (
		reqValid && reqOp == OP_MAC_READ && reqMode == AM_INDIRECT && !reqPointer[0]
		&& reqPointer > 16'h0fff && reqPointer <= RAM_LAST && macYMode == AM_INDIRECT
		&& !macYPointer[0] && macYPointer >= XY_SPLIT && macYPointer <= RAM_LAST
		&& readPageSelect == HOME_PAGE
		|=> bothRead ##2 macValid)
		else $error("dual read missing");
endmodule // data_space_access_unit_chk
`default_nettype wire

/* File: verification/data_memory_model.sv */
// data ram and peripheral registers behind the access unit
`timescale 1ns/1ps
`default_nettype none
module data_memory_model #(
	parameter logic [15:0] SFR_USED = 16'h0800
) (
	input wire logic sys_clk,
	input wire logic xRdEn,
	input wire logic [23:0] xRdAddr,
	input wire logic xRdSfr,
	output logic [15:0] xRdData,
	output logic xRdHit,
	input wire logic yRdEn,
	input wire logic [23:0] yRdAddr,
	output logic [15:0] yRdData,
	input wire logic [1:0] wrStrobe,
	input wire logic [23:0] wrAddr,
	input wire logic [15:0] wrData
);
	// ----------
	// storage
	// ----------
	logic [15:0] mem [logic [23:0]];
	logic [15:0] w;
	// unwritten words show an address pattern
	function automatic logic [15:0] peek(input logic [23:0] a);
		return mem.exists(a) ? mem[a] : a[15:0] ^ 16'ha5c3;
	endfunction
	// only the low part of the register area answers
	assign xRdHit = xRdEn && xRdSfr && xRdAddr[15:0] < SFR_USED;
	initial begin
		xRdData = 16'h0000;
		yRdData = 16'h0000;
	end
	// whole words one cycle later, lines toggle when idle
	always @(posedge sys_clk) begin
		xRdData <= xRdEn ? peek(xRdAddr) : ~xRdData;
		yRdData <= yRdEn ? peek(yRdAddr) : ~yRdData;
	end
	// one word decode, one strobe per byte lane
	always @(posedge sys_clk) begin
		if (wrStrobe != 2'h0) begin
			w = peek(wrAddr);
			if (wrStrobe[0]) w[7:0] = wrData[7:0];
			if (wrStrobe[1]) w[15:8] = wrData[15:8];
			mem[wrAddr] = w;
		end
	end
endmodule // data_memory_model
`default_nettype wire

/* File: verification/data_space_access_unit_test.sv */
// self-checking bench of the data space access unit
`timescale 1ns/1ps
`default_nettype none
module data_space_access_unit_test;
	import dsa_pkg::*;
	// ----------
	// wiring
	// ----------
	logic sys_clk = 1'b0, rst_b = 1'b0, reqValid = 1'b0, reqByte = 1'b0;
	op_t reqOp = OP_IDLE;
	amode_t reqMode = AM_DIRECT16, macYMode = AM_INDIRECT;
	ext_t reqExt = EXT_NONE;
	logic [15:0] reqDirect = 16'h0000, reqPointer = 16'h0000, reqRegOld = 16'h0000;
	logic [15:0] reqWriteData = 16'h0000, macYPointer = 16'h0000, reqRevStep = 16'h0000;
	logic [15:0] reqModStart = 16'h1000, reqModEnd = 16'h1fff;
	logic [7:0] readPageSelect = 8'h00, writePageSelect = 8'h00;
	logic [15:0] pointerNext, pointerNextY, rspData, macXData, macYData, trapAddr;
	logic [15:0] xRdData, yRdData, wrData, got, pnx;
	logic pointerValid, rspValid, macValid, addrErrorTrap, xRdEn, xRdSfr, xRdHit;
	logic yRdEn, wrSfr, trap, xen, yen, sfr, pv;
	logic [23:0] xRdAddr, yRdAddr, wrAddr;
	logic [1:0] wrStrobe, strb;
	int errCount = 0, checksDone = 0;
	always #4 sys_clk = ~sys_clk;
	data_space_access_unit data_space_access_unit_i (.sys_clk, .rst_b, .reqValid, .reqOp,
		.reqByte, .reqMode, .reqDirect, .reqPointer, .reqModStart, .reqModEnd, .reqRevStep,
		.reqExt, .reqRegOld, .reqWriteData, .macYMode, .macYPointer, .readPageSelect,
		.writePageSelect, .pointerNext, .pointerNextY, .pointerValid, .rspValid, .rspData,
		.macValid, .macXData, .macYData, .addrErrorTrap, .trapAddr, .xRdEn, .xRdAddr, .xRdSfr,
		.xRdData, .xRdHit, .yRdEn, .yRdAddr, .yRdData, .wrStrobe, .wrAddr, .wrData, .wrSfr);
	data_memory_model data_memory_model_i (.sys_clk, .xRdEn, .xRdAddr, .xRdSfr, .xRdData,
		.xRdHit, .yRdEn, .yRdAddr, .yRdData, .wrStrobe, .wrAddr, .wrData);
	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		checksDone++;
		if (seen !== exp) begin
			errCount++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finishTest();
		$display("checks %0d mismatches %0d", checksDone, errCount);
		if (errCount == 0 && checksDone > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// one request, next-cycle answer captured, load result fetched
	task automatic req(input op_t op, input logic bt, input amode_t md, input logic [15:0] a,
		input logic [15:0] wd, input ext_t ex, input logic [15:0] old);
		reqOp = op;
		reqByte = bt;
		reqMode = md;
		reqDirect = a;
		reqPointer = a;
		reqWriteData = wd;
		reqExt = ex;
		reqRegOld = old;
		reqValid = 1'b1;
		@(posedge sys_clk);
		#1;
		reqValid = 1'b0;
		strb = wrStrobe;
		trap = addrErrorTrap;
		xen = xRdEn;
		yen = yRdEn;
		sfr = (op == OP_WRITE) ? wrSfr : xRdSfr;
		pnx = pointerNext;
		pv = pointerValid;
		if (op != OP_WRITE) begin
			repeat (2) @(posedge sys_clk);
			#1;
			chk(rspValid | macValid, 1'b1);
			got = (op == OP_MAC_READ) ? macXData : rspData;
		end else begin
			@(posedge sys_clk);
			#1;
		end
	endtask
	task automatic rd(input logic bt, input logic [15:0] a, input ext_t ex = EXT_NONE,
		input logic [15:0] old = 16'h0000);
		req(OP_READ, bt, AM_DIRECT16, a, 16'h0000, ex, old);
	endtask
	task automatic wr(input logic bt, input logic [15:0] a, input logic [15:0] d);
		req(OP_WRITE, bt, AM_DIRECT16, a, d, EXT_NONE, 16'h0000);
	endtask
	task automatic lanesTest();
		wr(1'b0, 16'h1000, 16'h80f0);
		chk(strb, 2'h3);
		rd(1'b1, 16'h1001, EXT_NONE, 16'habcd);
		chk(got, 16'hab80);
		rd(1'b1, 16'h1001, EXT_SIGN, 16'habcd);
		chk(got, 16'hff80);
		rd(1'b1, 16'h1000, EXT_ZERO, 16'habcd);
		chk(got, 16'h00f0);
		rd(1'b1, 16'h1000, EXT_NONE, 16'h1234);
		chk(got, 16'h12f0);
		wr(1'b1, 16'h1001, 16'h0077);
		chk(strb, 2'h2);
		rd(1'b0, 16'h1000);
		chk(got, 16'h77f0);
		$display("test lanes done");
	endtask
	task automatic alignTest();
		wr(1'b0, 16'h1004, 16'h2222);
		wr(1'b0, 16'h1005, 16'h1111);
		chk(strb, 2'h0);
		chk(trap, 1'b1);
		chk(trapAddr, 16'h1005);
		rd(1'b0, 16'h1005);
		chk(trap, 1'b1);
		chk(got, 16'h2222);
		$display("test align done");
	endtask
	task automatic mapTest();
		wr(1'b1, 16'he000, 16'h00aa);
		chk({strb, trap}, 3'h0);
		rd(1'b0, 16'hd000);
		chk({xen, got}, 17'h00000);
		rd(1'b0, 16'hcffe);
		chk(xen, 1'b1);
		wr(1'b0, 16'h0010, 16'h4321);
		chk({strb, sfr}, 3'h7);
		rd(1'b0, 16'h0010);
		chk({sfr, got}, 17'h14321);
		rd(1'b0, 16'h0f00);
		chk(got, 16'h0000);
		readPageSelect = 8'h01;
		rd(1'b0, 16'h1000);
		chk(got, 16'h0000);
		chk(xRdAddr, 24'h011000);
		wr(1'b0, 16'h1002, 16'h3333);
		chk(strb, 2'h3);
		readPageSelect = 8'h00;
		writePageSelect = 8'h01;
		wr(1'b0, 16'h1000, 16'h9999);
		chk(strb, 2'h0);
		chk(wrAddr, 24'h011000);
		writePageSelect = 8'h00;
		rd(1'b0, 16'h1000);
		chk(got, 16'h77f0);
		$display("test map done");
	endtask
	task automatic pointerTest();
		amode_t md [5] = '{AM_POST_INC, AM_POST_INC, AM_POST_DEC, AM_POST_DEC, AM_MODULO};
		logic bt [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
		logic [15:0] pt [5] = '{16'h1000, 16'h1000, 16'h1000, 16'h1000, 16'h1ffe};
		logic [15:0] ex [5] = '{16'h1001, 16'h1002, 16'h0fff, 16'h0ffe, 16'h1000};
		for (int i = 0; i < 5; i++) begin
			req(OP_READ, bt[i], md[i], pt[i], 16'h0000, EXT_NONE, 16'h0000);
			chk({pv, pnx}, {1'b1, ex[i]});
		end
		reqRevStep = 16'h0100;
		req(OP_WRITE, 1'b0, AM_BIT_REV, 16'h1100, 16'h0000, EXT_NONE, 16'h0000);
		chk(pnx, 16'h1080);
		req(OP_READ, 1'b0, AM_BIT_REV, 16'h1100, 16'h0000, EXT_NONE, 16'h0000);
		chk(pnx, 16'h1102);
		$display("test pointer done");
	endtask
	task automatic dualTest();
		wr(1'b0, 16'h8000, 16'h5aa5);
		wr(1'b0, 16'h1010, 16'h1357);
		macYPointer = 16'h8000;
		req(OP_MAC_READ, 1'b0, AM_INDIRECT, 16'h1010, 16'h0000, EXT_NONE, 16'h0000);
		chk({yen, got, macYData}, 33'h113575aa5);
		macYPointer = 16'h1000;
		macYMode = AM_POST_INC;
		req(OP_MAC_READ, 1'b0, AM_INDIRECT, 16'h1010, 16'h0000, EXT_NONE, 16'h0000);
		chk({yen, macYData}, 17'h00000);
		chk(pointerNextY, 16'h1002);
		req(OP_READ, 1'b0, AM_DIRECT13, 16'hf010, 16'h0000, EXT_NONE, 16'h0000);
		chk(got, 16'h1357);
		req(OP_READ, 1'b0, AM_INDIRECT, 16'h8000, 16'h0000, EXT_NONE, 16'h0000);
		chk(got, 16'h5aa5);
		$display("test dual done");
	endtask
	// reset, then every scenario in turn
	initial begin
		repeat (6) @(posedge sys_clk);
		#1;
		rst_b = 1'b1;
		lanesTest();
		alignTest();
		mapTest();
		pointerTest();
		dualTest();
		finishTest();
	end
endmodule // data_space_access_unit_test
bind data_space_access_unit data_space_access_unit_chk #(.RAM_LAST(RAM_LAST),
	.XY_SPLIT(XY_SPLIT), .HOME_PAGE(HOME_PAGE)) data_space_access_unit_chk_i (.sys_clk, .rst_b,
	.reqValid, .reqOp, .reqByte, .reqMode, .reqDirect, .reqPointer, .reqWriteData, .macYMode,
	.macYPointer, .readPageSelect, .writePageSelect, .rspValid, .rspData, .macValid,
	.addrErrorTrap, .trapAddr, .xRdEn, .xRdAddr, .xRdSfr, .yRdEn, .wrStrobe, .wrAddr, .wrData);
`default_nettype wire
